//--- src/display_scan_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_display_consts.svh"

module display_scan_controller
#(
	parameter int unsigned DWELL_CYCLES = `DIGIT_DWELL_CYCLES
)
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	display_link_if.processor_end link,
	input wire logic pattern_write_in,
	input wire led_display_pkg::digit_index_type pattern_digit_in,
	input wire led_display_pkg::segment_type pattern_value_in,
	input wire led_display_pkg::column_type alpha_column_on_in,
	output var led_display_pkg::digit_index_type scan_digit_out
);
	import led_display_pkg::*;

	// ------------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------------
	localparam int POSITIONS [3] = '{`SHIFTER_A_POSITIONS,
		`SHIFTER_B_POSITIONS, `SHIFTER_C_POSITIONS};
	localparam int USED [3] = '{`SHIFTER_A_USED, `SHIFTER_B_USED,
		`SHIFTER_C_USED};
	localparam int BASE [3] = '{0, `SHIFTER_A_USED,
		`SHIFTER_A_USED + `SHIFTER_B_USED};
	localparam int START_BIT [3] = '{`CTL_START_A_BIT, `CTL_START_B_BIT,
		`CTL_START_C_BIT};
	localparam logic [31:0] STROBE_LAST = 32'(`LATCH_STROBE_CYCLES - 1);
	localparam logic [31:0] PULSE = 32'(`SHIFT_PULSE_CYCLES);

	segment_type pattern_r [`NUMERIC_DIGITS];
	scan_state_type state_r;
	logic [31:0] timer_r;
	logic [31:0] strobe_cnt_r;
	logic [2:0] write_idx_r;
	logic [1:0] shifter_r;
	logic [4:0] pos_r;
	logic [4:0] next_pos;
	logic [4:0] cur_digit;
	logic strobe_r;
	logic [3:0] seg_lines_r;
	logic [3:0] ctl_lines_r;
	logic clear_n_r;
	logic drive_n_r;
	control_type ctl_image;
	segment_type seg_target;

	assign next_pos = pos_r + 5'h01;
	// The digit number is formed here, not taken from the registered output,
	// so port lines loaded in the first cycle of a dwell already carry the new digit.
	assign cur_digit = 5'(BASE[shifter_r]) + pos_r;
	assign link.latch_update_strobe = strobe_r;
	assign link.segment_port_lines = seg_lines_r;
	assign link.control_port_lines = ctl_lines_r;
	assign link.segment_clear_n = clear_n_r;
	assign link.shift_clock_drive_n = drive_n_r;

	// ------------------------------------------------------------------
	// Character memory and latch images
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (pattern_write_in && pattern_digit_in < 5'(`NUMERIC_DIGITS))
			pattern_r[pattern_digit_in] <= pattern_value_in;
	end

	always_comb
	begin
		ctl_image = 8'h00;
		// A column is energized by writing its bit low.
		ctl_image[`CTL_COL1_BIT] = ~alpha_column_on_in[0];
		ctl_image[`CTL_COL2_BIT] = ~alpha_column_on_in[1];
		ctl_image[`CTL_COL3_BIT] = ~alpha_column_on_in[2];
		ctl_image[`CTL_COL4_BIT] = ~alpha_column_on_in[3];
		ctl_image[`CTL_COL5_BIT] = ~alpha_column_on_in[4];
		if (state_r == scan_start_on)
			ctl_image[START_BIT[shifter_r]] = 1'b1;
		// Segments stay dark outside the dwell of a used digit.
		seg_target = (state_r == scan_dwell) ? pattern_r[cur_digit] :
			8'h00;
	end

	// ------------------------------------------------------------------
	// Latch strobe divider and port lines
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			strobe_cnt_r <= 32'h0;
			strobe_r <= 1'b0;
			write_idx_r <= 3'h0;
			seg_lines_r <= 4'h0;
			ctl_lines_r <= 4'h0;
		end
		else
		begin
			strobe_cnt_r <= (strobe_cnt_r == STROBE_LAST) ? 32'h0 :
				strobe_cnt_r + 32'h1;
			strobe_r <= (strobe_cnt_r == 32'h1);
			if (strobe_cnt_r == 32'h0)
			begin
				seg_lines_r <= {seg_target[write_idx_r], write_idx_r};
				ctl_lines_r <= {ctl_image[write_idx_r], write_idx_r};
			end
			if (strobe_cnt_r == 32'h1)
				write_idx_r <= write_idx_r + 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= scan_start_on;
			timer_r <= 32'(`START_HOLD_CYCLES - 1);
			shifter_r <= 2'h0;
			pos_r <= 5'h1f;
		end
		else if (timer_r != 32'h0)
			timer_r <= timer_r - 32'h1;
		else
		begin
			case (state_r)
				scan_start_on:
				begin
					state_r <= scan_start_off;
					timer_r <= 32'(`START_HOLD_CYCLES - 1);
				end
				scan_start_off:
				begin
					pos_r <= 5'h1f;
					state_r <= scan_shift;
					timer_r <= 32'(2 * `SHIFT_PULSE_CYCLES - 1);
				end
				scan_shift:
				begin
					pos_r <= next_pos;
					if (next_pos == 5'(POSITIONS[shifter_r]))
					begin
						// After the last shifter the scan restarts at digit 0.
						shifter_r <= (shifter_r == 2'h2) ? 2'h0 :
							shifter_r + 2'h1;
						state_r <= scan_start_on;
						timer_r <= 32'(`START_HOLD_CYCLES - 1);
					end
					else if (next_pos < 5'(USED[shifter_r]))
					begin
						state_r <= scan_dwell;
						timer_r <= 32'(DWELL_CYCLES - 1);
					end
					else
						timer_r <= 32'(2 * `SHIFT_PULSE_CYCLES - 1);
				end
				scan_dwell:
				begin
					state_r <= scan_blank;
					timer_r <= 32'(`CLEAR_PULSE_CYCLES - 1);
				end
				scan_blank:
				begin
					state_r <= scan_shift;
					timer_r <= 32'(2 * `SHIFT_PULSE_CYCLES - 1);
				end
				default:
				begin
					state_r <= scan_start_on;
					timer_r <= 32'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Clear pulse, shift clock and digit number
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			clear_n_r <= 1'b1;
			// The drive idles released, so the shift clock idles low.
			drive_n_r <= 1'b1;
			scan_digit_out <= 5'h00;
		end
		else
		begin
			clear_n_r <= (state_r != scan_blank);
			// Pulling the drive low for the first half and then releasing it
			// makes one shift edge.
			drive_n_r <= !(state_r == scan_shift && timer_r >= PULSE);
			scan_digit_out <= cur_digit;
		end
	end

endmodule : display_scan_controller

`default_nettype wire

//--- pkg/led_display_consts.svh
`ifndef LED_DISPLAY_CONSTS_SVH
`define LED_DISPLAY_CONSTS_SVH

// ----------------------------------------------------------------------
// Display geometry
// ----------------------------------------------------------------------
`define NUMERIC_DIGITS 31
`define SEGMENT_COUNT 8
`define SHIFTER_A_POSITIONS 15
`define SHIFTER_B_POSITIONS 15
`define SHIFTER_C_POSITIONS 5
`define SHIFTER_A_USED 13
`define SHIFTER_B_USED 13
`define SHIFTER_C_USED 5

// ----------------------------------------------------------------------
// Port line layout and control latch bits
// ----------------------------------------------------------------------
`define PORT_ADDR_MSB 2
`define PORT_DATA_BIT 3
`define CTL_START_A_BIT 4
`define CTL_START_B_BIT 5
`define CTL_START_C_BIT 7
`define CTL_COL1_BIT 2
`define CTL_COL2_BIT 1
`define CTL_COL3_BIT 0
`define CTL_COL4_BIT 3
`define CTL_COL5_BIT 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SEGMENT_RESET 8'h00
`define CONTROL_RESET 8'h4f

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define CLK_HZ 100000000
`define LATCH_STROBE_PERIOD_NS 1360
`define SHIFT_PULSE_NS 3000
`define CLEAR_PULSE_US 20
`define SCAN_RATE_HZ 80
`define LATCH_STROBE_CYCLES ((`LATCH_STROBE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHIFT_PULSE_CYCLES ((`SHIFT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_PULSE_CYCLES ((`CLEAR_PULSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_HOLD_CYCLES (9 * `LATCH_STROBE_CYCLES)
`define DIGIT_DWELL_CYCLES (`CLK_HZ / (`SCAN_RATE_HZ * `NUMERIC_DIGITS))

`endif

//--- pkg/led_display_pkg.sv
package led_display_pkg;

	typedef logic [7:0] segment_type;
	typedef logic [7:0] control_type;
	typedef logic [4:0] digit_index_type;
	typedef logic [4:0] column_type;
	typedef logic [2:0] start_type;
	typedef logic [30:0] digit_select_type;

	typedef enum logic [2:0]
	{
		scan_start_on,
		scan_start_off,
		scan_shift,
		scan_dwell,
		scan_blank
	} scan_state_type;

endpackage : led_display_pkg

//--- pkg/display_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface display_link_if;
	logic latch_update_strobe;
	logic [3:0] segment_port_lines;
	logic [3:0] control_port_lines;
	logic segment_clear_n;
	logic shift_clock_drive_n;

	modport processor_end
	(
		output latch_update_strobe,
		output segment_port_lines,
		output control_port_lines,
		output segment_clear_n,
		output shift_clock_drive_n
	);

	modport driver_end
	(
		input latch_update_strobe,
		input segment_port_lines,
		input control_port_lines,
		input segment_clear_n,
		input shift_clock_drive_n
	);
endinterface : display_link_if

`default_nettype wire

//--- src/led_digit_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_display_consts.svh"

// How it works
// - Eight shared segments, one select per digit
// - Controller clears segments, selects first digit
// - Controller blanks segments then shifts digit
// - Controller dwells on each digit
// - Controller walks 31 digits, repeats 80 Hz
// - Segment latch: 3-bit address, one data bit
// - Each strobe updates only the addressed bit
// - High segment latch bit lights segment
// - Start pulse drives all shifter outputs high
// - First shift after start lowers output zero
// - Each shift moves the low one place
// - Low leaves past last line, all high
// - Low select lights enabled segments of digit
// - Control latch: addressable, updated every strobe
// - Control bits 4,5,7 start the shifters
// - Bits 0,1,2,3,6 select columns 3,2,1,4,5
// - Controller energizes a column by writing low
// - Shift clock translator inverts its input
// - Start translators pass level without inversion
// - Larger shifters use 13 of 15 positions
// - Clear input low blanks every segment
module led_digit_driver
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	display_link_if.driver_end link,
	output var led_display_pkg::segment_type segment_enable_out,
	output var led_display_pkg::digit_select_type digit_select_n_out,
	output var led_display_pkg::column_type alpha_column_out,
	output var led_display_pkg::start_type start_level_out,
	output var logic shift_clock_out
);
	import led_display_pkg::*;

	// ------------------------------------------------------------------
	// Shifter geometry
	// ------------------------------------------------------------------
	localparam int POSITIONS [3] = '{`SHIFTER_A_POSITIONS,
		`SHIFTER_B_POSITIONS, `SHIFTER_C_POSITIONS};
	localparam int USED [3] = '{`SHIFTER_A_USED, `SHIFTER_B_USED,
		`SHIFTER_C_USED};
	localparam int BASE [3] = '{0, `SHIFTER_A_USED,
		`SHIFTER_A_USED + `SHIFTER_B_USED};

	segment_type segment_latch_r;
	control_type control_latch_r;
	logic shift_clock_prev_r;
	logic shift_fall;
	start_type start_level;
	logic [2:0] seg_addr;
	logic [2:0] ctl_addr;
	logic seg_data;
	logic ctl_data;

	assign seg_addr = link.segment_port_lines[`PORT_ADDR_MSB:0];
	assign seg_data = link.segment_port_lines[`PORT_DATA_BIT];
	assign ctl_addr = link.control_port_lines[`PORT_ADDR_MSB:0];
	assign ctl_data = link.control_port_lines[`PORT_DATA_BIT];

	// ------------------------------------------------------------------
	// Segment latch
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			segment_latch_r <= `SEGMENT_RESET;
		else if (!link.segment_clear_n)
			segment_latch_r <= `SEGMENT_RESET;
		else if (link.latch_update_strobe)
			segment_latch_r[seg_addr] <= seg_data;
	end

	// A high bit turns its segment current source on.
	assign segment_enable_out = segment_latch_r;

	// ------------------------------------------------------------------
	// Control latch
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			control_latch_r <= `CONTROL_RESET;
		else if (link.latch_update_strobe)
			control_latch_r[ctl_addr] <= ctl_data;
	end

	// A low control bit turns its column driver on.
	always_comb
	begin
		alpha_column_out[0] = ~control_latch_r[`CTL_COL1_BIT];
		alpha_column_out[1] = ~control_latch_r[`CTL_COL2_BIT];
		alpha_column_out[2] = ~control_latch_r[`CTL_COL3_BIT];
		alpha_column_out[3] = ~control_latch_r[`CTL_COL4_BIT];
		alpha_column_out[4] = ~control_latch_r[`CTL_COL5_BIT];
	end

	// ------------------------------------------------------------------
	// Level translators
	// ------------------------------------------------------------------
	always_comb
	begin
		start_level[0] = control_latch_r[`CTL_START_A_BIT];
		start_level[1] = control_latch_r[`CTL_START_B_BIT];
		start_level[2] = control_latch_r[`CTL_START_C_BIT];
	end

	assign start_level_out = start_level;
	assign shift_clock_out = ~link.shift_clock_drive_n;

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		// Reset matches the idle low clock so no false edge follows reset.
		if (!reset_n_in)
			shift_clock_prev_r <= 1'b0;
		else
			shift_clock_prev_r <= shift_clock_out;
	end

	// Shifters advance on the falling edge of the translated clock.
	assign shift_fall = shift_clock_prev_r && !shift_clock_out;

	// ------------------------------------------------------------------
	// Digit shifters
	// ------------------------------------------------------------------
	for (genvar g = 0; g < 3; g++)
	begin : shifter
		localparam int P = POSITIONS[g];
		localparam int U = USED[g];
		localparam int B = BASE[g];
		logic [P-1:0] outs_r;
		logic armed_r;

		always_ff @(posedge clk_in or negedge reset_n_in)
		begin
			if (!reset_n_in)
			begin
				outs_r <= '1;
				armed_r <= 1'b0;
			end
			else if (start_level[g])
			begin
				outs_r <= '1;
				armed_r <= 1'b1;
			end
			else if (shift_fall)
			begin
				// The top bit drops out, so the low leaves the register.
				outs_r <= {outs_r[P-2:0], ~armed_r};
				armed_r <= 1'b0;
			end
		end

		// Only the first positions of a shifter reach a digit.
		assign digit_select_n_out[B+U-1:B] = outs_r[U-1:0];
	end

endmodule : led_digit_driver

`default_nettype wire

//--- dv/led_digit_driver_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module led_digit_driver_assertions
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic latch_update_strobe,
	input wire logic [3:0] segment_port_lines,
	input wire logic [3:0] control_port_lines,
	input wire logic segment_clear_n,
	input wire logic shift_clock_drive_n,
	input wire led_display_pkg::segment_type segment_enable_out,
	input wire led_display_pkg::digit_select_type digit_select_n_out,
	input wire led_display_pkg::column_type alpha_column_out,
	input wire led_display_pkg::start_type start_level_out,
	input wire logic shift_clock_out
);
	import led_display_pkg::*;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence seg_write_s;
		latch_update_strobe && segment_clear_n;
	endsequence

	sequence shift_rise_s;
		!shift_clock_drive_n ##1 shift_clock_drive_n;
	endsequence

	seg_write_a: assert property (
		seg_write_s |=> segment_enable_out[$past(segment_port_lines[2:0])]
		== $past(segment_port_lines[3])) else $error("segment bit not set");
	seg_keep_a: assert property (
		!latch_update_strobe && segment_clear_n |=>
		$stable(segment_enable_out)) else $error("segment latch drifted");
	seg_clear_a: assert property (
		!segment_clear_n |=> segment_enable_out == 8'h00)
		else $error("clear did not blank segments");
	col_three_a: assert property (
		latch_update_strobe && control_port_lines[2:0] == 3'h0 |=>
		alpha_column_out[2] == !$past(control_port_lines[3]))
		else $error("column three wrong");
	col_five_a: assert property (
		latch_update_strobe && control_port_lines[2:0] == 3'h6 |=>
		alpha_column_out[4] == !$past(control_port_lines[3]))
		else $error("column five wrong");
	start_bit_a: assert property (
		latch_update_strobe && control_port_lines[2:0] == 3'h7 |=>
		start_level_out[2] == $past(control_port_lines[3]))
		else $error("start level wrong");
	clk_invert_a: assert property (
		shift_clock_out == !shift_clock_drive_n)
		else $error("shift clock not inverted");
	start_clear_a: assert property (
		start_level_out[0] |=> &digit_select_n_out[12:0])
		else $error("start left a digit on");
	shift_step_a: assert property (
		shift_rise_s ##0 (!start_level_out[0] && !digit_select_n_out[0])
		|=> digit_select_n_out[1:0] == 2'b01)
		else $error("low output did not move");
	one_low_a: assert property (
		$countones(~digit_select_n_out[12:0]) <= 1)
		else $error("two digits selected");
endmodule : led_digit_driver_assertions

`default_nettype wire

//--- dv/led_multiplex_display_driver_bench.sv
`timescale 1ns/1ps
`default_nettype none

module led_multiplex_display_driver_bench;
	import led_display_pkg::*;

	// Dwell must cover eight strobes so every segment bit is written.
	localparam int unsigned DWELL = 1500;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic pattern_write_in = 1'b0;
	digit_index_type pattern_digit_in = 5'h00;
	segment_type pattern_value_in = 8'h00;
	column_type alpha_column_on_in = 5'h00;
	digit_index_type scan_digit_out;
	segment_type segment_enable_out;
	digit_select_type digit_select_n_out;
	column_type alpha_column_out;
	start_type start_level_out;
	logic shift_clock_out;
	int bad_count = 0;
	int n_compared = 0;

	display_link_if link();
	display_scan_controller #(.DWELL_CYCLES(DWELL)) u_display_scan_controller
	(.clk_in, .reset_n_in, .link(link.processor_end), .pattern_write_in,
		.pattern_digit_in, .pattern_value_in, .alpha_column_on_in,
		.scan_digit_out);
	led_digit_driver u_led_digit_driver
	(.clk_in, .reset_n_in, .link(link.driver_end), .segment_enable_out,
		.digit_select_n_out, .alpha_column_out, .start_level_out,
		.shift_clock_out);
	led_digit_driver_assertions u_led_digit_driver_assertions
	(.clk_in, .reset_n_in, .latch_update_strobe(link.latch_update_strobe),
		.segment_port_lines(link.segment_port_lines),
		.control_port_lines(link.control_port_lines),
		.segment_clear_n(link.segment_clear_n),
		.shift_clock_drive_n(link.shift_clock_drive_n), .segment_enable_out,
		.digit_select_n_out, .alpha_column_out, .start_level_out,
		.shift_clock_out);

	always #5 clk_in = ~clk_in;

	function automatic segment_type pat(input int i);
		return 8'(i * 37 + 5);
	endfunction : pat

	task automatic check(input logic [30:0] seen, input logic [30:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("compares %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic test_reset();
		@(negedge clk_in);
		check(31'(segment_enable_out), 31'h0);
		check(digit_select_n_out, 31'h7fffffff);
		check(31'(alpha_column_out), 31'h0);
		check(31'(start_level_out), 31'h0);
		$display("reset test done");
	endtask : test_reset

	task automatic test_patterns();
		for (int i = 0; i < 31; i++)
		begin
			@(posedge clk_in);
			pattern_write_in <= 1'b1;
			pattern_digit_in <= 5'(i);
			pattern_value_in <= pat(i);
		end
		@(posedge clk_in);
		pattern_write_in <= 1'b0;
		@(negedge clk_in);
		check(31'(segment_enable_out), 31'h0);
		$display("pattern test done");
	endtask : test_patterns

	task automatic test_start();
		for (int k = 0; k < 2000 && start_level_out !== 3'h1; k++)
			@(negedge clk_in);
		check(31'(start_level_out), 31'h1);
		@(negedge clk_in);
		check(digit_select_n_out, 31'h7fffffff);
		$display("start test done");
	endtask : test_start

	task automatic test_columns(input column_type v);
		@(posedge clk_in);
		alpha_column_on_in <= v;
		for (int k = 0; k < 2000 && alpha_column_out !== v; k++)
			@(negedge clk_in);
		check(31'(alpha_column_out), 31'(v));
		$display("column test done");
	endtask : test_columns

	task automatic test_walk();
		for (int d = 0; d < 3; d++)
		begin
			for (int k = 0; k < 6000 && digit_select_n_out !== ~(31'h1 << d);
				k++)
				@(negedge clk_in);
			check(digit_select_n_out, ~(31'h1 << d));
			check(31'(segment_enable_out), 31'h0);
			for (int k = 0; k < 2500 && segment_enable_out !== pat(d); k++)
				@(negedge clk_in);
			check(31'(segment_enable_out), 31'(pat(d)));
			check(31'(scan_digit_out), 31'(d));
		end
		$display("walk test done");
	endtask : test_walk

	task automatic test_next_shifter();
		for (int k = 0; k < 50000 && start_level_out !== 3'h2; k++)
			@(negedge clk_in);
		check(31'(start_level_out), 31'h2);
		check(digit_select_n_out, 31'h7fffffff);
		for (int k = 0; k < 4000 && digit_select_n_out !== ~(31'h1 << 13);
			k++)
			@(negedge clk_in);
		check(digit_select_n_out, ~(31'h1 << 13));
		$display("next shifter test done");
	endtask : test_next_shifter

	initial
	begin
		repeat (90000) @(posedge clk_in);
		bad_count++;
		$display("unexpected at %0t: run hung", $time);
		end_sim();
	end

	initial
	begin
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		test_reset();
		test_patterns();
		test_start();
		test_columns(5'h15);
		test_columns(5'h0a);
		test_walk();
		test_next_shifter();
		end_sim();
	end
endmodule : led_multiplex_display_driver_bench

`default_nettype wire
